// ### hw/dspm_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R01: index pin defaults to decoder index input
// R02: index pull-up on at reset, port c bit6
// R03: home pin defaults to decoder home input
// R04: home pull-up on at reset, port c bit7
// R05: spi clock driven as master, input as slave
// R06: spi clock pull-up on, port e bit4
// R07: master-out data changes half cycle before sampling
// R08: master-out driver off in reset, pull-up bit5
// R09: unselected slave floats master-in pin
// R10: slave drives master-in half cycle early
// R11: master-in pull-up on, port e bit6
// R12: slave-select low marks slave transfer received
// R13: slave-select pull-up on, port e bit7
// R14: gpio pins individually input or output
// R15: per-pin peripheral or gpio select, peripheral default
module dspm_pin_mux (
  input wire logic clk_in,
  input wire logic nrst_in,
  // spi link clock domain for slave mode
  input wire logic spi_link_clk_in,
  // configuration bits
  input wire logic [7:0] port_c_pullup_enable_reg_in,
  input wire logic [7:0] port_e_pullup_enable_reg_in,
  input wire logic [7:0] gpio_select_in,
  input wire logic [7:0] gpio_dir_out_in,
  input wire logic [7:0] gpio_data_in,
  input wire logic idx_timer_sel_in,
  input wire logic home_timer_sel_in,
  input wire logic spi_master_in,
  // timer channel drive for decoder pins
  input wire logic timer_a_channel_two_out_in,
  input wire logic timer_a_channel_two_oe_in,
  input wire logic timer_a_channel_three_out_in,
  input wire logic timer_a_channel_three_oe_in,
  // spi word interface
  input wire logic [7:0] spi_tx_data_in,
  input wire logic spi_tx_start_in,
  // pads: input, output, output enable (low drives)
  input wire logic idx_pad_in,
  output logic idx_pad_out,
  output logic idx_pad_oe_n_out,
  output logic idx_pullup_out,
  input wire logic home_pad_in,
  output logic home_pad_out,
  output logic home_pad_oe_n_out,
  output logic home_pullup_out,
  input wire logic spi_zero_clock_pin_in,
  output logic spi_zero_clock_pin_out,
  output logic spi_zero_clock_pin_oe_n_out,
  output logic spi_zero_clock_pin_pullup_out,
  input wire logic spi_zero_master_out_pin_in,
  output logic spi_zero_master_out_pin_out,
  output logic spi_zero_master_out_pin_oe_n_out,
  output logic spi_zero_master_out_pin_pullup_out,
  input wire logic spi_zero_master_in_pin_in,
  output logic spi_zero_master_in_pin_out,
  output logic spi_zero_master_in_pin_oe_n_out,
  output logic spi_zero_master_in_pin_pullup_out,
  input wire logic spi_zero_slave_select_pin_in,
  output logic spi_zero_slave_select_pin_out,
  output logic spi_zero_slave_select_pin_oe_n_out,
  output logic spi_zero_slave_select_pin_pullup_out,
  // peripheral side results
  output logic decoder0_index_input_out,
  output logic decoder0_home_input_out,
  output logic timer_a_channel_two_in_out,
  output logic timer_a_channel_three_in_out,
  output logic [7:0] gpio_pin_level_out,
  output logic [7:0] spi_rx_data_out,
  output logic spi_rx_valid_out,
  output logic spi_busy_out
);
  // gpio vector layout: [0] index, [1] home, [4..7] spi pins, others spare
  localparam int G_IDX = 0;
  localparam int G_HOME = 1;
  localparam int HALF = dspm_pkg::SPI_HALF_CYC;
  localparam int NB = dspm_pkg::SPI_BITS;

  // synchronised pad levels in the system domain
  logic [5:0] pad_raw;
  logic [5:0] pad_s;
  assign pad_raw = {spi_zero_slave_select_pin_in, spi_zero_master_in_pin_in,
                    spi_zero_master_out_pin_in, spi_zero_clock_pin_in,
                    home_pad_in, idx_pad_in};
  dspm_sync #(.W(6)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in(pad_raw),
    .q_out(pad_s)
  );

  // per-pin function selection, one means gpio
  function automatic logic is_gpio(input logic [7:0] sel, input int b);
    return sel[b];
  endfunction

  // master state machine
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b100
  } dspm_mst_t;
  dspm_mst_t mst_q;
  logic [7:0] div_q; // half period counter
  logic [3:0] bit_q; // bits remaining
  logic [7:0] mtx_q; // master shift out
  logic [7:0] mrx_q; // master shift in
  logic sclk_q; // generated clock
  logic m_done_q; // one-cycle completion

  // master: data set on falling half, sampled on rising edge (mode 0)
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mst_q <= M_IDLE;
      div_q <= 8'h00;
      bit_q <= 4'h0;
      mtx_q <= 8'h00;
      mrx_q <= 8'h00;
      sclk_q <= 1'b0;
      m_done_q <= 1'b0;
    end else begin
      m_done_q <= 1'b0;
      unique case (mst_q)
        M_IDLE: begin
          sclk_q <= 1'b0;
          if (spi_tx_start_in && spi_master_in) begin
            mtx_q <= spi_tx_data_in; // first bit out half cycle ahead [R07]
            bit_q <= 4'(NB);
            div_q <= 8'h00;
            mst_q <= M_LOW;
          end
        end
        M_LOW: begin
          if (div_q == 8'(HALF - 1)) begin
            div_q <= 8'h00;
            sclk_q <= 1'b1; // rising edge: slave samples [R07]
            mrx_q <= {mrx_q[6:0], pad_s[4]}; // latch master-in [R10]
            mst_q <= M_HIGH;
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        M_HIGH: begin
          if (div_q == 8'(HALF - 1)) begin
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            mtx_q <= {mtx_q[6:0], 1'b0}; // next bit half cycle early [R07]
            if (bit_q == 4'h1) begin
              mst_q <= M_IDLE;
              m_done_q <= 1'b1;
            end else begin
              bit_q <= bit_q - 4'h1;
              mst_q <= M_LOW;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
      endcase
    end
  end

  // slave logic on the link clock; select released resets it
  logic sl_rst_n;
  assign sl_rst_n = nrst_in & ~spi_zero_slave_select_pin_in;
  logic [7:0] stx_q; // slave shift out
  logic [7:0] srx_q; // slave shift in
  logic [3:0] scnt_q; // bits received
  logic [7:0] sword_q; // completed word held for crossing
  logic stog_q; // toggles per completed word
  // slave receives while selected [R12]
  always_ff @(posedge spi_link_clk_in or negedge sl_rst_n) begin
    if (!sl_rst_n) begin
      srx_q <= 8'h00;
      scnt_q <= 4'h0;
    end else begin
      srx_q <= {srx_q[6:0], spi_zero_master_out_pin_in};
      scnt_q <= (scnt_q == 4'(NB - 1)) ? 4'h0 : scnt_q + 4'h1;
    end
  end
  // completed word and toggle survive deselect for the crossing
  always_ff @(posedge spi_link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sword_q <= 8'h00;
      stog_q <= 1'b0;
    end else if (!spi_zero_slave_select_pin_in && scnt_q == 4'(NB - 1)) begin
      sword_q <= {srx_q[6:0], spi_zero_master_out_pin_in}; // [R12]
      stog_q <= ~stog_q;
    end
  end
  // slave output shifts on falling edge, half cycle before master samples
  always_ff @(negedge spi_link_clk_in or negedge sl_rst_n) begin
    if (!sl_rst_n) begin
      stx_q <= 8'h00;
    end else if (scnt_q == 4'h1) begin
      // msb already left via the preload, so load the remaining bits
      stx_q <= {spi_tx_data_in[6:0], 1'b0}; // [R10]
    end else begin
      stx_q <= {stx_q[6:0], 1'b0}; // [R10]
    end
  end
  // transmit word preloaded in the system domain, msb first
  logic slv_msb;
  assign slv_msb = (scnt_q == 4'h0) ? spi_tx_data_in[7] : stx_q[7];

  // toggle crossing into the system domain
  logic [1:0] tog_s;
  logic tog_d_q;
  dspm_sync #(.W(1)) u_tog (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in(stog_q),
    .q_out(tog_s[0])
  );
  assign tog_s[1] = tog_d_q;
  // edge of toggle: capture stable slave word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_d_q <= 1'b0;
      spi_rx_data_out <= 8'h00;
      spi_rx_valid_out <= 1'b0;
    end else begin
      tog_d_q <= tog_s[0];
      spi_rx_valid_out <= m_done_q | (tog_s[0] ^ tog_s[1]);
      if (m_done_q) begin
        spi_rx_data_out <= mrx_q;
      end else if (tog_s[0] ^ tog_s[1]) begin
        spi_rx_data_out <= sword_q;
      end
    end
  end

  // slave select seen in the system domain
  logic ss_active;
  assign ss_active = !spi_master_in && !pad_s[5];

  // registered pad drive; oe_n low means the pad is driven
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // all pads input, pulls on, peripheral function [R01] [R03] [R08]
      idx_pad_out <= 1'b0;
      idx_pad_oe_n_out <= 1'b1;
      home_pad_out <= 1'b0;
      home_pad_oe_n_out <= 1'b1;
      spi_zero_clock_pin_out <= 1'b0;
      spi_zero_clock_pin_oe_n_out <= 1'b1;
      spi_zero_master_out_pin_out <= 1'b0;
      spi_zero_master_out_pin_oe_n_out <= 1'b1;
      spi_zero_master_in_pin_out <= 1'b0;
      spi_zero_master_in_pin_oe_n_out <= 1'b1;
      spi_zero_slave_select_pin_out <= 1'b0;
      spi_zero_slave_select_pin_oe_n_out <= 1'b1;
    end else begin
      // index: gpio, timer or decoder input [R01] [R14] [R15]
      if (is_gpio(gpio_select_in, G_IDX)) begin
        idx_pad_out <= gpio_data_in[G_IDX];
        idx_pad_oe_n_out <= ~gpio_dir_out_in[G_IDX]; // [R14]
      end else if (idx_timer_sel_in) begin
        idx_pad_out <= timer_a_channel_two_out_in;
        idx_pad_oe_n_out <= ~timer_a_channel_two_oe_in;
      end else begin
        idx_pad_out <= 1'b0;
        idx_pad_oe_n_out <= 1'b1;
      end
      // home: gpio, timer or decoder input [R03] [R14] [R15]
      if (is_gpio(gpio_select_in, G_HOME)) begin
        home_pad_out <= gpio_data_in[G_HOME];
        home_pad_oe_n_out <= ~gpio_dir_out_in[G_HOME]; // [R14]
      end else if (home_timer_sel_in) begin
        home_pad_out <= timer_a_channel_three_out_in;
        home_pad_oe_n_out <= ~timer_a_channel_three_oe_in;
      end else begin
        home_pad_out <= 1'b0;
        home_pad_oe_n_out <= 1'b1;
      end
      // spi clock: output as master, input as slave [R05]
      if (is_gpio(gpio_select_in, dspm_pkg::PE_CLK_BIT)) begin
        spi_zero_clock_pin_out <= gpio_data_in[dspm_pkg::PE_CLK_BIT];
        spi_zero_clock_pin_oe_n_out <= ~gpio_dir_out_in[dspm_pkg::PE_CLK_BIT];
      end else begin
        spi_zero_clock_pin_out <= sclk_q; // [R05]
        spi_zero_clock_pin_oe_n_out <= ~spi_master_in; // [R05]
      end
      // master-out: gpio, or in spi function driven by master only [R07]
      if (is_gpio(gpio_select_in, dspm_pkg::PE_MOSI_BIT)) begin
        spi_zero_master_out_pin_out <= gpio_data_in[dspm_pkg::PE_MOSI_BIT];
        spi_zero_master_out_pin_oe_n_out <= ~gpio_dir_out_in[dspm_pkg::PE_MOSI_BIT];
      end else begin
        spi_zero_master_out_pin_out <= mtx_q[7]; // [R07]
        spi_zero_master_out_pin_oe_n_out <= ~spi_master_in; // [R07]
      end
      // master-in: gpio, or in spi function driven only by a selected slave [R09] [R10]
      if (is_gpio(gpio_select_in, dspm_pkg::PE_MISO_BIT)) begin
        spi_zero_master_in_pin_out <= gpio_data_in[dspm_pkg::PE_MISO_BIT];
        spi_zero_master_in_pin_oe_n_out <= ~gpio_dir_out_in[dspm_pkg::PE_MISO_BIT];
      end else begin
        spi_zero_master_in_pin_out <= slv_msb; // [R10]
        spi_zero_master_in_pin_oe_n_out <= ~ss_active; // [R09]
      end
      // slave select: input in spi function [R12]
      if (is_gpio(gpio_select_in, dspm_pkg::PE_SS_BIT)) begin
        spi_zero_slave_select_pin_out <= gpio_data_in[dspm_pkg::PE_SS_BIT];
        spi_zero_slave_select_pin_oe_n_out <= ~gpio_dir_out_in[dspm_pkg::PE_SS_BIT];
      end else begin
        spi_zero_slave_select_pin_out <= 1'b0;
        spi_zero_slave_select_pin_oe_n_out <= 1'b1; // [R12]
      end
    end
  end

  // pull-ups follow register bits, on during reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_pullup_out <= 1'b1; // [R02]
      home_pullup_out <= 1'b1; // [R04]
      spi_zero_clock_pin_pullup_out <= 1'b1; // [R06]
      spi_zero_master_out_pin_pullup_out <= 1'b1; // [R08]
      spi_zero_master_in_pin_pullup_out <= 1'b1; // [R11]
      spi_zero_slave_select_pin_pullup_out <= 1'b1; // [R13]
    end else begin
      idx_pullup_out <= port_c_pullup_enable_reg_in[dspm_pkg::PC_IDX_BIT]; // [R02]
      home_pullup_out <= port_c_pullup_enable_reg_in[dspm_pkg::PC_HOME_BIT]; // [R04]
      spi_zero_clock_pin_pullup_out <= port_e_pullup_enable_reg_in[dspm_pkg::PE_CLK_BIT]; // [R06]
      spi_zero_master_out_pin_pullup_out <=
        port_e_pullup_enable_reg_in[dspm_pkg::PE_MOSI_BIT]; // [R08]
      spi_zero_master_in_pin_pullup_out <=
        port_e_pullup_enable_reg_in[dspm_pkg::PE_MISO_BIT]; // [R11]
      spi_zero_slave_select_pin_pullup_out <=
        port_e_pullup_enable_reg_in[dspm_pkg::PE_SS_BIT]; // [R13]
    end
  end

  // inward routes to decoder, timer and gpio readback
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      decoder0_index_input_out <= 1'b0;
      decoder0_home_input_out <= 1'b0;
      timer_a_channel_two_in_out <= 1'b0;
      timer_a_channel_three_in_out <= 1'b0;
      gpio_pin_level_out <= 8'h00;
      spi_busy_out <= 1'b0;
    end else begin
      decoder0_index_input_out <= !gpio_select_in[G_IDX] && !idx_timer_sel_in
                                  && pad_s[0]; // [R01]
      decoder0_home_input_out <= !gpio_select_in[G_HOME] && !home_timer_sel_in
                                 && pad_s[1]; // [R03]
      timer_a_channel_two_in_out <= pad_s[0];
      timer_a_channel_three_in_out <= pad_s[1];
      gpio_pin_level_out <= {pad_s[5:2], 2'b00, pad_s[1:0]}; // [R14]
      spi_busy_out <= (mst_q != M_IDLE) || ss_active;
    end
  end
endmodule
`default_nettype wire

// ### hw/dspm_pkg.sv
package dspm_pkg;
  // port c pull-up register bit positions for the decoder pins
  localparam int PC_IDX_BIT = 6;
  localparam int PC_HOME_BIT = 7;
  // port e pull-up register bit positions for the spi pins
  localparam int PE_CLK_BIT = 4;
  localparam int PE_MOSI_BIT = 5;
  localparam int PE_MISO_BIT = 6;
  localparam int PE_SS_BIT = 7;
  // reset values: all pull-ups on, all pins on their peripheral function
  localparam logic [7:0] PUR_RST = 8'hFF;
  localparam logic [7:0] SEL_RST = 8'h00;
  // spi clock divider: half period in system clocks
  localparam int SPI_HALF_CYC = 4;
  // link shift length
  localparam int SPI_BITS = 8;
  // pin mode select codes for the two decoder pins
  typedef enum logic [1:0] {
    DSPM_FN_DECODER = 2'h0,
    DSPM_FN_TIMER = 2'h1,
    DSPM_FN_GPIO = 2'h2
  } dspm_fn_t;
endpackage

// ### hw/dspm_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two flip-flop synchroniser for a bus of levels
module dspm_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q; // first stage, read only by second stage
  // two stage capture
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### verification/dspm_chk.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks beside the pin mux
module dspm_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] port_c_pullup_enable_reg_in,
  input wire logic [7:0] port_e_pullup_enable_reg_in,
  input wire logic [7:0] gpio_select_in,
  input wire logic idx_timer_sel_in,
  input wire logic spi_master_in,
  input wire logic idx_pad_in,
  input wire logic spi_zero_slave_select_pin_in,
  input wire logic idx_pullup_out,
  input wire logic home_pullup_out,
  input wire logic spi_zero_clock_pin_pullup_out,
  input wire logic spi_zero_master_out_pin_pullup_out,
  input wire logic spi_zero_master_in_pin_pullup_out,
  input wire logic spi_zero_slave_select_pin_pullup_out,
  input wire logic spi_zero_clock_pin_out,
  input wire logic spi_zero_clock_pin_oe_n_out,
  input wire logic spi_zero_master_out_pin_out,
  input wire logic spi_zero_master_in_pin_oe_n_out,
  input wire logic decoder0_index_input_out,
  input wire logic spi_rx_valid_out
);
  // one clock domain, reset low aborts every attempt
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // pulls hold their reset value until one edge after release
  a_idx_pull_track: assert property (
    $past(nrst_in) |-> idx_pullup_out == $past(port_c_pullup_enable_reg_in[6]))
    else $error("index pull wrong");
  a_home_pull_track: assert property (
    $past(nrst_in) |-> home_pullup_out == $past(port_c_pullup_enable_reg_in[7]))
    else $error("home pull wrong");
  a_spi_pull_track: assert property (
    $past(nrst_in) |->
    {spi_zero_slave_select_pin_pullup_out, spi_zero_master_in_pin_pullup_out,
     spi_zero_master_out_pin_pullup_out, spi_zero_clock_pin_pullup_out}
    == $past(port_e_pullup_enable_reg_in[7:4])) else $error("spi pulls wrong");
  a_idx_route_decoder: assert property (
    (!gpio_select_in[0] && !idx_timer_sel_in && $stable(idx_pad_in)) [*5]
    |-> decoder0_index_input_out == idx_pad_in) else $error("index not routed");
  a_clock_role_dir: assert property (
    !$past(gpio_select_in[4])
    |-> spi_zero_clock_pin_oe_n_out == !$past(spi_master_in)) else $error("clock dir wrong");
  a_miso_float_unsel: assert property (
    (!spi_master_in && !gpio_select_in[6] && spi_zero_slave_select_pin_in) [*6]
    |-> spi_zero_master_in_pin_oe_n_out) else $error("unselected slave drives");
  a_mosi_lead_edge: assert property (
    spi_master_in && $rose(spi_zero_clock_pin_out)
    |-> $past(spi_zero_master_out_pin_out, 3) == spi_zero_master_out_pin_out)
    else $error("data moved near edge");
  a_rx_valid_single: assert property (
    spi_rx_valid_out |=> !spi_rx_valid_out) else $error("strobe too long");
  // main scenarios reached
  c_master_word: cover property (spi_master_in && spi_rx_valid_out);
  c_slave_word: cover property (!spi_master_in && spi_rx_valid_out);
  c_index_decoder: cover property (!gpio_select_in[0] && decoder0_index_input_out);
endmodule
bind dspm_pin_mux dspm_chk u_chk (.*);
`default_nettype wire

// ### verification/dspm_spi_peer.sv
`timescale 1ns/100ps
`default_nettype none
// far-side spi peer: slave when device is master, master otherwise
module dspm_spi_peer (
  input wire logic osc_in,
  input wire logic mst_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic miso_out,
  output logic ss_n_out
);
  logic run; // link clock runs only inside frames
  logic [7:0] tx, rx; // reply word and captured word
  assign sclk_out = osc_in & run;
  assign miso_out = tx[7];
  // reply advances on falling clock, half a cycle before sampling
  always @(negedge sclk_in) if (mst_in) tx <= {tx[6:0], tx[7]};
  // capture on rising clock
  always @(posedge sclk_in) rx <= {rx[6:0], mst_in ? mosi_in : miso_in};
  initial begin
    run = 1'b0;
    tx = 8'h00;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
  end
  // one framed word, msb first, data set while clock low
  task automatic xfer(input logic [7:0] d);
    ss_n_out = 1'b0;
    repeat (2) @(negedge osc_in);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = d[i];
      run = 1'b1;
      @(negedge osc_in);
    end
    run = 1'b0;
    mosi_out = ~mosi_out; // no stale bit once released
    repeat (2) @(negedge osc_in);
    ss_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the decoder and spi pin mux
module testbench;
  logic clk_in, nrst_in, spi_link_clk_in, idx_timer_sel_in, home_timer_sel_in, spi_master_in;
  logic [7:0] port_c_pullup_enable_reg_in, port_e_pullup_enable_reg_in, gpio_select_in;
  logic [7:0] gpio_dir_out_in, gpio_data_in, spi_tx_data_in, spi_rx_data_out, gpio_pin_level_out;
  logic timer_a_channel_two_out_in, timer_a_channel_two_oe_in, timer_a_channel_three_out_in;
  logic timer_a_channel_three_oe_in, spi_tx_start_in, spi_rx_valid_out, spi_busy_out;
  logic idx_pad_in, idx_pad_out, idx_pad_oe_n_out, idx_pullup_out, decoder0_index_input_out;
  logic home_pad_in, home_pad_out, home_pad_oe_n_out, home_pullup_out, decoder0_home_input_out;
  logic spi_zero_clock_pin_in, spi_zero_clock_pin_out, spi_zero_clock_pin_oe_n_out;
  logic spi_zero_master_out_pin_in, spi_zero_master_out_pin_out, spi_zero_master_out_pin_oe_n_out;
  logic spi_zero_master_in_pin_in, spi_zero_master_in_pin_out, spi_zero_master_in_pin_oe_n_out;
  logic spi_zero_slave_select_pin_in, spi_zero_slave_select_pin_out;
  logic spi_zero_slave_select_pin_oe_n_out, spi_zero_clock_pin_pullup_out;
  logic spi_zero_master_out_pin_pullup_out, spi_zero_master_in_pin_pullup_out;
  logic spi_zero_slave_select_pin_pullup_out, timer_a_channel_two_in_out;
  logic timer_a_channel_three_in_out, osc, idx_drv, home_drv, p_sclk, p_mosi, p_miso, p_ss_n;
  logic [7:0] r, rep; // sent and replied words
  logic [31:0] w; // one random draw per routing step
  integer seed;
  int fails, tests_run, n;
  // pad levels resolved from every driver
  assign idx_pad_in = !idx_pad_oe_n_out ? idx_pad_out : idx_drv;
  assign home_pad_in = !home_pad_oe_n_out ? home_pad_out : home_drv;
  assign spi_link_clk_in = p_sclk;
  assign spi_zero_clock_pin_in = !spi_zero_clock_pin_oe_n_out ? spi_zero_clock_pin_out : p_sclk;
  assign spi_zero_master_out_pin_in = !spi_zero_master_out_pin_oe_n_out ?
    spi_zero_master_out_pin_out : p_mosi;
  assign spi_zero_master_in_pin_in = !spi_zero_master_in_pin_oe_n_out ?
    spi_zero_master_in_pin_out : spi_master_in ? p_miso : ~p_miso;
  assign spi_zero_slave_select_pin_in = !spi_zero_slave_select_pin_oe_n_out ?
    spi_zero_slave_select_pin_out : p_ss_n;
  dspm_spi_peer peer (.osc_in(osc), .mst_in(spi_master_in), .sclk_in(spi_zero_clock_pin_in),
    .mosi_in(spi_zero_master_out_pin_in), .miso_in(spi_zero_master_in_pin_in),
    .sclk_out(p_sclk), .mosi_out(p_mosi), .miso_out(p_miso), .ss_n_out(p_ss_n));
  dspm_pin_mux dut (.*);
  // 200 MHz system clock, 32 ns link oscillator out of phase
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    osc = 1'b0;
    #1.3;
    forever #16 osc = ~osc;
  end
  // expected {oe_n, driven level}: gpio first, then timer
  function automatic logic [1:0] pad_exp(input logic g, d, v, t, toe, tout);
    if (g) return {~d, d & v};
    if (t) return {~toe, toe & tout};
    return 2'b10;
  endfunction
  // word the far side answers with
  function automatic logic [7:0] reply(input logic [7:0] b);
    return {b[3:0], b[7:4]} ^ 8'hA5;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // pad drive and inward routing of one decoder pin
  task automatic pin_chk(input string nm, input logic g, d, v, t, toe, tout, oe_n, o, p, dec, tin,
                         lvl);
    chk(nm, {6'h0, pad_exp(g, d, v, t, toe, tout)}, {6'h0, oe_n, ~oe_n & o});
    if (g) chk(nm, {7'h0, p}, {7'h0, lvl});
    else if (t) chk(nm, {7'h0, p}, {7'h0, tin});
    else chk(nm, {7'h0, p}, {7'h0, dec});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // bounded wait for the received-word strobe
  task automatic wait_valid();
    for (n = 0; n < 400 && spi_rx_valid_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 400) begin
      fails++;
      finish_test();
    end
  endtask
  initial begin
    seed = 32'hA1456544;
    {fails, tests_run, nrst_in, spi_master_in, spi_tx_start_in, idx_drv, home_drv} = '0;
    {idx_timer_sel_in, home_timer_sel_in, timer_a_channel_two_out_in} = '0;
    {timer_a_channel_two_oe_in, timer_a_channel_three_out_in, timer_a_channel_three_oe_in} = '0;
    {port_c_pullup_enable_reg_in, port_e_pullup_enable_reg_in, gpio_select_in} = '0;
    {gpio_dir_out_in, gpio_data_in, spi_tx_data_in} = '0;
    repeat (10) @(posedge clk_in);
    // in reset pulls stay on and drivers off even with enables cleared
    chk("reset pulls", 8'h3F, {2'h0, idx_pullup_out, home_pullup_out,
      spi_zero_clock_pin_pullup_out, spi_zero_master_out_pin_pullup_out,
      spi_zero_master_in_pin_pullup_out, spi_zero_slave_select_pin_pullup_out});
    chk("reset oe_n", 8'h03, {6'h0, spi_zero_master_out_pin_oe_n_out, idx_pad_oe_n_out});
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    // random pin functions and pull enables, first step with all controls cleared
    for (int k = 0; k < 24; k++) begin
      @(posedge clk_in);
      w = (k == 0) ? 32'h0 : $random(seed);
      {port_c_pullup_enable_reg_in, port_e_pullup_enable_reg_in} <= {w[31:24], w[15:8]};
      gpio_select_in <= {6'h00, w[1:0]};
      {idx_timer_sel_in, home_timer_sel_in, idx_drv, home_drv} <= w[7:4];
      {gpio_dir_out_in, gpio_data_in} <= w[23:8];
      {timer_a_channel_two_out_in, timer_a_channel_two_oe_in, timer_a_channel_three_out_in,
       timer_a_channel_three_oe_in} <= w[27:24];
      repeat (8) @(negedge clk_in);
      pin_chk("index", w[0], w[16], w[8], w[7], w[26], w[27], idx_pad_oe_n_out, idx_pad_out,
        idx_pad_in, decoder0_index_input_out, timer_a_channel_two_in_out, gpio_pin_level_out[0]);
      pin_chk("home", w[1], w[17], w[9], w[6], w[24], w[25], home_pad_oe_n_out, home_pad_out,
        home_pad_in, decoder0_home_input_out, timer_a_channel_three_in_out, gpio_pin_level_out[1]);
      chk("c pulls", {6'h0, w[31:30]}, {6'h0, home_pullup_out, idx_pullup_out});
      chk("e pulls", {4'h0, w[15:12]}, {4'h0, spi_zero_slave_select_pin_pullup_out,
        spi_zero_master_in_pin_pullup_out, spi_zero_master_out_pin_pullup_out,
        spi_zero_clock_pin_pullup_out});
    end
    @(posedge clk_in);
    spi_master_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    // master words back to back, boundary words first
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      r = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      peer.tx = reply(r);
      spi_tx_data_in <= r;
      spi_tx_start_in <= 1'b1;
      @(posedge clk_in);
      spi_tx_start_in <= 1'b0;
      if (k == 2) begin
        repeat (9) @(posedge clk_in);
        spi_tx_start_in <= 1'b1; // refused while busy
        @(posedge clk_in);
        spi_tx_start_in <= 1'b0;
      end
      wait_valid();
      chk("master rx", reply(r), spi_rx_data_out);
      chk("peer rx", r, peer.rx);
      chk("clock oe_n", 8'h00, {7'h0, spi_zero_clock_pin_oe_n_out});
    end
    @(posedge clk_in);
    spi_master_in <= 1'b0;
    // slave words framed by the far-side master
    for (int k = 0; k < 6; k++) begin
      repeat (8) @(negedge clk_in);
      chk("clock oe_n", 8'h01, {7'h0, spi_zero_clock_pin_oe_n_out});
      chk("miso oe_n", 8'h01, {7'h0, spi_zero_master_in_pin_oe_n_out});
      @(posedge clk_in);
      r = (k == 0) ? 8'hFF : 8'($random(seed));
      rep = (k == 0) ? 8'h00 : 8'($random(seed));
      spi_tx_data_in <= rep;
      @(posedge clk_in);
      fork
        peer.xfer(r);
        wait_valid();
      join
      chk("slave rx", r, spi_rx_data_out);
      chk("slave tx", rep, peer.rx);
    end
    finish_test();
  end
endmodule
`default_nettype wire
